// *** core/plc_regs.svh ***
// register offsets, reset values and line masks of the parallel line controller
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
`define PLC_OWN_EN_OFS     8'h00
`define PLC_OWN_DIS_OFS    8'h04
`define PLC_OWN_ST_OFS     8'h08
`define PLC_DIR_EN_OFS     8'h10
`define PLC_DIR_DIS_OFS    8'h14
`define PLC_DIR_ST_OFS     8'h18
`define PLC_FLT_EN_OFS     8'h20
`define PLC_FLT_DIS_OFS    8'h24
`define PLC_FLT_ST_OFS     8'h28
`define PLC_DRV_SET_OFS    8'h30
`define PLC_DRV_CLR_OFS    8'h34
`define PLC_DRV_ST_OFS     8'h38
`define PLC_PIN_ST_OFS     8'h3C
`define PLC_IRQ_EN_OFS     8'h40
`define PLC_IRQ_DIS_OFS    8'h44
`define PLC_IRQ_MASK_OFS   8'h48
`define PLC_EVT_OFS        8'h4C
`define PLC_OWN_RST        32'h01FFFFFF
`define PLC_ZERO_RST       32'h00000000
`define PLC_DEDICATED_MASK 32'h018F0000
`define PLC_FLT_LEN        2'h3
`endif

// *** core/plc_pkg.sv ***
// types shared by the parallel line controller files
package plc_pkg;
	typedef logic [31:0] plc_word_t;
	typedef logic [7:0]  plc_addr_t;
	typedef logic [1:0]  plc_cnt_t;
endpackage

// *** core/plc_glitch_filter.sv ***
// per-line glitch filter: a level must persist before it passes
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_glitch_filter (
	input  wire logic           clk_i,
	input  wire logic           srst_i,
	input  wire logic           raw_i,
	input  wire logic           enable_i,
	output logic                level_o
);
	plc_pkg::plc_cnt_t cnt_ff;
	logic              flt_ff;

	// filtered level updates only after a stable run; short pulses never pass
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_ff <= 2'h0;
			flt_ff <= 1'b0;
		end else if (raw_i == flt_ff) begin
			cnt_ff <= 2'h0;
		end else if (cnt_ff == `PLC_FLT_LEN) begin
			flt_ff <= raw_i;
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end

	// bypass keeps a disabled line at synchroniser latency
	assign level_o = enable_i ? flt_ff : raw_i;
endmodule // plc_glitch_filter

// *** core/plc_line_controller.sv ***
// parallel line controller: 32 lines, ownership mux, direction, pin change irq
`timescale 1ns/1ps
`include "plc_regs.svh"
// Summary of operation
// - thirty-two lines, bit n of every register serves line n
// - dedicated lines 16-19, 23, 24 ignore ownership writes, read as one
// - reset: lines 0-24 controller-owned inputs, 25-31 peripheral-owned
// - ownership enable/disable switch owner; state register reports it
// - peripheral input forced to zero while controller owns the line
// - every line usable in both directions under controller ownership
// - direction bit always stored, acts on pin only under controller
// - set/clear registers program driven level, readable in drive state
// - controller-owned input line is left undriven
// - peripheral-owned line takes drive and value from the peripheral
// - pin level state returns synchronised pin levels, filtered on lines whose filter is on
// - per-line glitch filter switched on and off, applies to both owners
// - filter state register reports which filters are active
// - irq enable sets, irq disable clears the readable irq mask
// - any change of the filtered pin level sets its event flag regardless of owner
// - interrupt request raised while any flagged line is unmasked
// - reading event flags returns contents then clears them
// - registers 32 bits wide, absent bits ignore writes, read zero
// - writing one acts on the line, writing zero leaves it alone
module plc_line_controller (
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	input  wire logic [7:0]  ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	input  wire logic [31:0] PIN_I,
	output logic      [31:0] PIN_O,
	output logic      [31:0] PIN_OE_O,
	input  wire logic [31:0] PERIPH_OUT_I,
	input  wire logic [31:0] PERIPH_OE_I,
	output logic      [31:0] PERIPH_IN_O,
	output logic             IRQ_O
);
	plc_pkg::plc_word_t own_ff;
	plc_pkg::plc_word_t dir_ff;
	plc_pkg::plc_word_t drv_ff;
	plc_pkg::plc_word_t flt_ff;
	plc_pkg::plc_word_t mask_ff;
	plc_pkg::plc_word_t evt_ff;
	plc_pkg::plc_word_t sync1_ff;
	plc_pkg::plc_word_t sync2_ff;
	plc_pkg::plc_word_t prev_ff;
	plc_pkg::plc_word_t level;
	plc_pkg::plc_word_t nxt_rdata;
	logic               started_ff;

	function automatic logic wr_at(input plc_pkg::plc_addr_t ofs);
		return WR_I && (ADDR_I == ofs);
	endfunction

	// -------------------------------------------------------------
	// pin input synchroniser and filters
	// -------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			sync1_ff <= `PLC_ZERO_RST;
			sync2_ff <= `PLC_ZERO_RST;
		end else begin
			sync1_ff <= PIN_I;
			sync2_ff <= sync1_ff;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_flt
			plc_glitch_filter u_flt (
				.clk_i    (CLK_I),
				.srst_i   (SRST_I),
				.raw_i    (sync2_ff[g]),
				.enable_i (flt_ff[g]),
				.level_o  (level[g])
			);
		end
	endgenerate

	// -------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------
	// ownership, dedicated lines pinned to one
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			own_ff <= `PLC_OWN_RST;
		end else begin
			own_ff <= ((own_ff | (wr_at(`PLC_OWN_EN_OFS) ? WDATA_I : '0))
				& ~(wr_at(`PLC_OWN_DIS_OFS) ? WDATA_I : '0))
				| `PLC_DEDICATED_MASK;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			dir_ff <= `PLC_ZERO_RST;
		end else begin
			dir_ff <= (dir_ff | (wr_at(`PLC_DIR_EN_OFS) ? WDATA_I : '0))
				& ~(wr_at(`PLC_DIR_DIS_OFS) ? WDATA_I : '0);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			drv_ff <= `PLC_ZERO_RST;
		end else begin
			drv_ff <= (drv_ff | (wr_at(`PLC_DRV_SET_OFS) ? WDATA_I : '0))
				& ~(wr_at(`PLC_DRV_CLR_OFS) ? WDATA_I : '0);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			flt_ff <= `PLC_ZERO_RST;
		end else begin
			flt_ff <= (flt_ff | (wr_at(`PLC_FLT_EN_OFS) ? WDATA_I : '0))
				& ~(wr_at(`PLC_FLT_DIS_OFS) ? WDATA_I : '0);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			mask_ff <= `PLC_ZERO_RST;
		end else begin
			mask_ff <= (mask_ff | (wr_at(`PLC_IRQ_EN_OFS) ? WDATA_I : '0))
				& ~(wr_at(`PLC_IRQ_DIS_OFS) ? WDATA_I : '0);
		end
	end

	// -------------------------------------------------------------
	// change detection and event flags
	// -------------------------------------------------------------
	// first cycle after reset only loads the reference, so no false event
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			prev_ff    <= `PLC_ZERO_RST;
			started_ff <= 1'b0;
		end else begin
			prev_ff    <= level;
			started_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			evt_ff <= `PLC_ZERO_RST;
		end else begin
			evt_ff <= ((RD_I && ADDR_I == `PLC_EVT_OFS) ? '0 : evt_ff)
				| (started_ff ? (level ^ prev_ff) : '0);
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(evt_ff & mask_ff);
		end
	end

	// -------------------------------------------------------------
	// pin and peripheral muxing
	// -------------------------------------------------------------
	// owner selects drive and value
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			PIN_O    <= `PLC_ZERO_RST;
			PIN_OE_O <= `PLC_ZERO_RST;
		end else begin
			PIN_O    <= (own_ff & drv_ff) | (~own_ff & PERIPH_OUT_I);
			PIN_OE_O <= (own_ff & dir_ff) | (~own_ff & PERIPH_OE_I);
		end
	end

	// peripheral inputs zero while controller owns
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			PERIPH_IN_O <= `PLC_ZERO_RST;
		end else begin
			PERIPH_IN_O <= level & ~own_ff;
		end
	end

	// -------------------------------------------------------------
	// read port
	// -------------------------------------------------------------
	// read decode, unmapped and write-only read zero
	always_comb begin
		nxt_rdata = '0;
		unique case (ADDR_I)
			`PLC_OWN_ST_OFS:   nxt_rdata = own_ff;
			`PLC_DIR_ST_OFS:   nxt_rdata = dir_ff;
			`PLC_FLT_ST_OFS:   nxt_rdata = flt_ff;
			`PLC_DRV_ST_OFS:   nxt_rdata = drv_ff;
			`PLC_PIN_ST_OFS:   nxt_rdata = level;
			`PLC_IRQ_MASK_OFS: nxt_rdata = mask_ff;
			`PLC_EVT_OFS:      nxt_rdata = evt_ff;
			default:           nxt_rdata = '0;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			RDATA_O <= `PLC_ZERO_RST;
		end else begin
			RDATA_O <= RD_I ? nxt_rdata : '0;
		end
	end
endmodule // plc_line_controller

// *** tb/plc_line_chk.sv ***
// port checker for the parallel line controller
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_line_chk (
	input wire logic        CLK_I,
	input wire logic        SRST_I,
	input wire logic [7:0]  ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic        WR_I,
	input wire logic        RD_I,
	input wire logic [31:0] RDATA_O,
	input wire logic [31:0] PIN_O,
	input wire logic [31:0] PIN_OE_O,
	input wire logic [31:0] PERIPH_IN_O,
	input wire logic        IRQ_O
);
	localparam logic [31:0] DED = `PLC_DEDICATED_MASK;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
		else $error("read data outside read slot");
	AST_OWN_DED: assert property ($past(RD_I) &&
		$past(ADDR_I) == `PLC_OWN_ST_OFS |-> (RDATA_O & DED) == DED)
		else $error("dedicated line not reported owned");
	AST_IN_DED: assert property ((PERIPH_IN_O & DED) == 32'h0)
		else $error("peripheral input not zero");
	AST_UNMAP: assert property ($past(RD_I) &&
		$past(ADDR_I) == 8'h0C |-> RDATA_O == 32'h0)
		else $error("reserved place reads nonzero");
	AST_IRQ_OFF: assert property (WR_I && WDATA_I == 32'hFFFFFFFF &&
		ADDR_I == `PLC_IRQ_DIS_OFS |-> ##2 !IRQ_O)
		else $error("request stays up after full mask");
	AST_RST: assert property ($fell(SRST_I) |-> !IRQ_O &&
		PIN_OE_O == 32'h0 && PERIPH_IN_O == 32'h0)
		else $error("outputs not idle after reset");
	AST_DIR_DED: assert property ($changed(PIN_OE_O & DED) |->
		$past(WR_I, 2)) else $error("direction moved without write");
	AST_DRV_DED: assert property ($changed(PIN_O & DED) |->
		$past(WR_I, 2)) else $error("drive moved without write");
endmodule // plc_line_chk
bind plc_line_controller plc_line_chk u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
	.RDATA_O(RDATA_O), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O),
	.PERIPH_IN_O(PERIPH_IN_O), .IRQ_O(IRQ_O));

// *** tb/plc_far_model.sv ***
// far side: pads resolving the drivers against the outside circuit
`timescale 1ns/1ps
module plc_far_model (
	input  wire logic [31:0] drv_i,
	input  wire logic [31:0] oe_i,
	input  wire logic [31:0] ext_i,
	output logic      [31:0] lvl_o
);
	assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // plc_far_model

// *** tb/plc_line_controller_tb.sv ***
// self-checking bench for the parallel line controller
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_line_controller_tb;
	logic        clk, srst, wr, rd, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, pin_i, pin_o, pin_oe;
	logic [31:0] p_out, p_oe, p_in, ext, d;
	int          n_errors, samples_checked;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	plc_line_controller DUT (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
		.PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
		.PERIPH_OUT_I(p_out), .PERIPH_OE_I(p_oe),
		.PERIPH_IN_O(p_in), .IRQ_O(irq));
	plc_far_model u_far (.drv_i(pin_o), .oe_i(pin_oe), .ext_i(ext),
		.lvl_o(pin_i));
	task automatic end_of_test();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrr(logic [7:0] a, logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
		chk(nm, d, e);
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic wait_irq(logic lvl);
		int k;
		for (k = 0; k < 20 && irq !== lvl; k++)
			@(posedge clk);
		#1;
		if (k == 20) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic t_reset();
		rdc("own", `PLC_OWN_ST_OFS, 32'h01FFFFFF);
		rdc("dir", `PLC_DIR_ST_OFS, 32'h0);
		rdc("drv", `PLC_DRV_ST_OFS, 32'h0);
		rdc("gap", 8'h0C, 32'h0);
	endtask
	task automatic t_own();
		wrr(`PLC_OWN_DIS_OFS, 32'hFFFFFFFF);
		rdc("own", `PLC_OWN_ST_OFS, 32'h018F0000);
		wrr(`PLC_OWN_EN_OFS, 32'h00000021);
		rdc("own", `PLC_OWN_ST_OFS, 32'h018F0021);
		wrr(`PLC_OWN_EN_OFS, 32'hFFFFFFFF);
		wrr(`PLC_OWN_DIS_OFS, 32'hFE000000);
		rdc("own", `PLC_OWN_ST_OFS, 32'h01FFFFFF);
	endtask
	task automatic t_drive();
		wrr(`PLC_DIR_EN_OFS, 32'h02010022);
		wrr(`PLC_DIR_DIS_OFS, 32'h00000020);
		rdc("dir", `PLC_DIR_ST_OFS, 32'h02010002);
		wrr(`PLC_DRV_SET_OFS, 32'h00010003);
		wrr(`PLC_DRV_CLR_OFS, 32'h00000001);
		rdc("drv", `PLC_DRV_ST_OFS, 32'h00010002);
		settle();
		chk("oe", pin_oe, 32'hFE010002);
		chk("out", pin_o, 32'h5A010002);
		rdc("pin", `PLC_PIN_ST_OFS, 32'h5A010002);
		chk("pin_in", p_in, 32'h5A000000);
		// peripheral enable must reach only peripheral-owned lines
		p_oe <= 32'h7FFFFFFF;
		settle();
		chk("oe_per", pin_oe, 32'h7E010002);
		p_oe <= 32'hFFFFFFFF;
		wrr(`PLC_FLT_EN_OFS, 32'h00000021);
		wrr(`PLC_FLT_DIS_OFS, 32'h00000001);
		rdc("flt", `PLC_FLT_ST_OFS, 32'h00000020);
	endtask
	task automatic t_irq();
		// flags also hold the lines that peripherals toggled in t_own
		rdc("evt", `PLC_EVT_OFS, 32'h5A515A5A);
		rdc("evt", `PLC_EVT_OFS, 32'h0);
		wrr(`PLC_IRQ_EN_OFS, 32'h00000020);
		rdc("mask", `PLC_IRQ_MASK_OFS, 32'h00000020);
		ext <= 32'h00000020;
		p_out <= 32'h5E5A5A5A;
		wait_irq(1'b1);
		rdc("evt", `PLC_EVT_OFS, 32'h04000020);
		wait_irq(1'b0);
		wrr(`PLC_IRQ_DIS_OFS, 32'hFFFFFFFF);
		ext <= 32'h0;
		settle();
		chk("irq", {31'h0, irq}, 32'h0);
	endtask
	initial begin
		srst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		ext = 32'h0;
		p_out = 32'h5A5A5A5A;
		p_oe = 32'hFFFFFFFF;
		n_errors = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_own();
		t_drive();
		t_irq();
		end_of_test();
	end
endmodule // plc_line_controller_tb
